// file: logic/stepper_diag_ctrl_regs.sv
// Diagnostic status register and control register bank of the stepper driver,
// with decoded outputs for the bridge, slew, indexer, off-time and decay logic.
// Assumes the serial port front end delivers single-cycle byte reads and writes.
`timescale 1ns/10ps
module stepper_diag_ctrl_regs
	import stepper_regs_pkg::*;
#(
	parameter int CNT_W       = 8,
	parameter int POS_W       = 10,
	parameter int OFFT0_CYCLES = (OFFT0_NS * CLK_MHZ) / 1000,
	parameter int OFFT1_CYCLES = (OFFT1_NS * CLK_MHZ) / 1000,
	parameter int OFFT2_CYCLES = (OFFT2_NS * CLK_MHZ) / 1000,
	parameter int OFFT3_CYCLES = (OFFT3_NS * CLK_MHZ) / 1000
) (
	input  wire logic                               sys_clk,
	input  wire logic                               reset,
	// Register port
	input  wire logic                               reg_wr_en,
	input  wire logic                               reg_rd_en,
	input  wire logic [stepper_regs_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [stepper_regs_pkg::DATA_W-1:0] reg_wdata,
	output logic      [stepper_regs_pkg::DATA_W-1:0] reg_rdata,
	output logic                                    reg_rd_valid,
	// Device status
	input  wire logic [CNT_W-1:0]                   torque_loop_count,
	input  wire logic [CNT_W-1:0]                   torque_upper_limit,
	input  wire logic [CNT_W-1:0]                   torque_lower_limit,
	input  wire logic [POS_W-1:0]                   indexer_position,
	input  wire logic [POS_W-1:0]                   zero_position,
	input  wire logic                               supply_uv_event,
	input  wire logic                               sleep_n,
	// Control outputs
	output logic                                    bridge_enable,
	output logic                                    slew_select,
	output logic [7:0]                              slew_time_ns,
	output logic                                    indexer_reset,
	output logic [1:0]                              off_time_select,
	output logic [stepper_regs_pkg::OFFT_CNT_W-1:0] off_time_cycles,
	output stepper_regs_pkg::fall_scheme_t          fall_scheme,
	output logic                                    clear_faults
);

	import stepper_regs_pkg::*;

	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------
	function automatic logic [NUM_CTRL-1:0] ctrl_hit(input logic [ADDR_W-1:0] a);
		logic [NUM_CTRL-1:0] h;
		h = '0;
		for (int i = 0; i < NUM_CTRL; i++) begin
			h[i] = (a == CTRL_OFFSETS[i]);
		end
		return h;
	endfunction : ctrl_hit

	function automatic fall_scheme_t scheme_decode(input logic [2:0] code);
		fall_scheme_t s;
		case (code)
			3'h0:    s = FALL_SLOW;
			3'h4:    s = FALL_MIXED_30;
			3'h5:    s = FALL_MIXED_60;
			3'h6:    s = FALL_DYNAMIC_TUNE;
			3'h7:    s = FALL_RIPPLE_TUNE;
			default: s = FALL_RESERVED;
		endcase
		return s;
	endfunction : scheme_decode

	wire [NUM_CTRL-1:0] hit_vec   = ctrl_hit(reg_addr);
	wire                diag_hit  = (reg_addr == DIAG_OFFSET);
	// Diagnostic offset is absent from the write path, so writes there fall away
	wire [NUM_CTRL-1:0] wr_vec    = hit_vec & {NUM_CTRL{reg_wr_en}};

	// ------------------------------------------------------------------
	// Control register bank
	// ------------------------------------------------------------------
	// Unpacked so that each register is owned by its own process
	logic [7:0] ctrl_q [NUM_CTRL];

	// Self-clearing bits are never stored, so they read back as zero
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CTRL; gi++) begin : g_ctrl
			localparam logic [7:0] SELF_CLR = (gi == FAULT_CTRL_IDX) ? CLR_FAULT_MASK : 8'h00;
			always_ff @(posedge sys_clk or posedge reset) begin
				if (reset) begin
					ctrl_q[gi] <= CTRL_RESETS[gi];
				end else if (wr_vec[gi]) begin
					ctrl_q[gi] <= reg_wdata & ~SELF_CLR;
				end
			end
		end
	endgenerate

	wire [7:0] cfg = ctrl_q[CFG_INDEX];

	// ------------------------------------------------------------------
	// Fault clear and supply flag
	// ------------------------------------------------------------------
	logic clear_faults_q;
	logic sleep_prev_q;
	logic supply_seen_q;

	wire clear_faults_d = wr_vec[FAULT_CTRL_IDX] & reg_wdata[CLR_FAULT_BIT];
	// Wake-up edge marks the end of a sleep reset pulse
	wire sleep_wake     = sleep_n & ~sleep_prev_q;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			clear_faults_q <= 1'b0;
			sleep_prev_q   <= 1'b1;
		end else begin
			clear_faults_q <= clear_faults_d;
			sleep_prev_q   <= sleep_n;
		end
	end

	// Undervoltage wins over a clear in the same cycle so the event is kept
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			supply_seen_q <= 1'b0;
		end else if (supply_uv_event) begin
			supply_seen_q <= 1'b0;
		end else if (clear_faults_q || sleep_wake) begin
			supply_seen_q <= 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Diagnostic comparators
	// ------------------------------------------------------------------
	logic above_q;
	logic below_q;
	logic away_q;

	torque_limit_compare #(
		.CNT_W (CNT_W),
		.POS_W (POS_W)
	) u_compare (
		.sys_clk            (sys_clk),
		.reset              (reset),
		.torque_loop_count  (torque_loop_count),
		.torque_upper_limit (torque_upper_limit),
		.torque_lower_limit (torque_lower_limit),
		.indexer_position   (indexer_position),
		.zero_position      (zero_position),
		.above_q            (above_q),
		.below_q            (below_q),
		.away_q             (away_q)
	);

	// Reserved bits are tied low so the whole register resets to zero
	logic [7:0] diag_word;
	always_comb begin
		diag_word                  = DIAG_RESET;
		diag_word[DIAG_AWAY_BIT]   = away_q;
		diag_word[DIAG_ABOVE_BIT]  = above_q;
		diag_word[DIAG_BELOW_BIT]  = below_q;
		diag_word[DIAG_SUPPLY_BIT] = supply_seen_q;
	end

	// ------------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------------
	logic [7:0] ctrl_rd;
	always_comb begin
		ctrl_rd = UNMAPPED_VALUE;
		for (int i = 0; i < NUM_CTRL; i++) begin
			if (hit_vec[i]) begin
				ctrl_rd = ctrl_q[i];
			end
		end
	end

	wire [7:0] rd_d = diag_hit ? diag_word : ctrl_rd;

	logic [7:0] reg_rdata_q;
	logic       reg_rd_valid_q;
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			reg_rdata_q    <= 8'h00;
			reg_rd_valid_q <= 1'b0;
		end else begin
			reg_rd_valid_q <= reg_rd_en;
			if (reg_rd_en) begin
				reg_rdata_q <= rd_d;
			end
		end
	end

	// ------------------------------------------------------------------
	// Decoded control outputs
	// ------------------------------------------------------------------
	logic [OFFT_CNT_W-1:0] off_time_d;
	always_comb begin
		case (cfg[OFFT_LSB +: 2])
			2'h0:    off_time_d = OFFT_CNT_W'(OFFT0_CYCLES);
			2'h1:    off_time_d = OFFT_CNT_W'(OFFT1_CYCLES);
			2'h2:    off_time_d = OFFT_CNT_W'(OFFT2_CYCLES);
			default: off_time_d = OFFT_CNT_W'(OFFT3_CYCLES);
		endcase
	end

	wire [7:0] slew_ns_d = cfg[SLEW_BIT] ? 8'(SLEW_FAST_NS) : 8'(SLEW_SLOW_NS);

	logic [OFFT_CNT_W-1:0] off_time_cycles_q;
	logic [7:0]            slew_time_q;
	fall_scheme_t          fall_scheme_q;
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			off_time_cycles_q <= OFFT_CNT_W'(OFFT1_CYCLES);
			slew_time_q       <= 8'(SLEW_SLOW_NS);
			fall_scheme_q     <= FALL_RIPPLE_TUNE;
		end else begin
			off_time_cycles_q <= off_time_d;
			slew_time_q       <= slew_ns_d;
			fall_scheme_q     <= scheme_decode(cfg[SCHEME_LSB +: 3]);
		end
	end

	// The indexer reset is a level; register contents are left alone
	assign bridge_enable   = cfg[OUT_EN_BIT];
	assign slew_select     = cfg[SLEW_BIT];
	assign indexer_reset   = cfg[INDEX_RST_BIT];
	assign off_time_select = cfg[OFFT_LSB +: 2];
	assign off_time_cycles = off_time_cycles_q;
	assign slew_time_ns    = slew_time_q;
	assign fall_scheme     = fall_scheme_q;
	assign clear_faults    = clear_faults_q;
	assign reg_rdata       = reg_rdata_q;
	assign reg_rd_valid    = reg_rd_valid_q;

endmodule : stepper_diag_ctrl_regs

// file: logic/stepper_regs_pkg.sv
// Constants for the diagnostic and control register bank of the stepper driver.
// Assumes a byte-wide register port and a single 250 MHz system clock.
package stepper_regs_pkg;

	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam int          ADDR_W         = 8;
	localparam int          DATA_W         = 8;
	localparam int          NUM_CTRL       = 14;
	localparam logic [7:0]  DIAG_OFFSET    = 8'h03;
	localparam logic [7:0]  DIAG_RESET     = 8'h00;
	localparam logic [7:0]  UNMAPPED_VALUE = 8'h00;

	// Index 0 holds the first control register, index 13 the last
	localparam logic [NUM_CTRL-1:0][7:0] CTRL_OFFSETS = {
		8'h3c, 8'h1a, 8'h0f, 8'h0e, 8'h0d, 8'h0c, 8'h0b,
		8'h0a, 8'h09, 8'h08, 8'h07, 8'h06, 8'h05, 8'h04
	};
	localparam logic [NUM_CTRL-1:0][7:0] CTRL_RESETS = {
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h49, 8'h38, 8'h06, 8'h0f
	};
	localparam int          CFG_INDEX      = 0;
	localparam int          FAULT_CTRL_IDX = 2;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int          DIAG_AWAY_BIT  = 6;
	localparam int          DIAG_ABOVE_BIT = 5;
	localparam int          DIAG_BELOW_BIT = 4;
	localparam int          DIAG_SUPPLY_BIT = 2;
	localparam int          OUT_EN_BIT     = 7;
	localparam int          SLEW_BIT       = 6;
	localparam int          INDEX_RST_BIT  = 5;
	localparam int          OFFT_LSB       = 3;
	localparam int          SCHEME_LSB     = 0;
	localparam int          CLR_FAULT_BIT  = 7;
	localparam logic [7:0]  CLR_FAULT_MASK = 8'h80;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int          CLK_MHZ        = 250;
	localparam int          OFFT0_NS       = 9500;
	localparam int          OFFT1_NS       = 19000;
	localparam int          OFFT2_NS       = 27000;
	localparam int          OFFT3_NS       = 35000;
	localparam int          SLEW_SLOW_NS   = 140;
	localparam int          SLEW_FAST_NS   = 70;
	localparam int          OFFT_CNT_W     = 14;

	typedef enum logic [2:0] {
		FALL_SLOW,
		FALL_MIXED_30,
		FALL_MIXED_60,
		FALL_DYNAMIC_TUNE,
		FALL_RIPPLE_TUNE,
		FALL_RESERVED
	} fall_scheme_t;

endpackage : stepper_regs_pkg

// file: logic/torque_limit_compare.sv
// Diagnostic comparators: auto-torque loop count against its window and
// indexer position against the zero position.
// Assumes all inputs are synchronous to sys_clk.
`timescale 1ns/10ps
module torque_limit_compare #(
	parameter int CNT_W  = 8,
	parameter int POS_W  = 10
) (
	input  wire logic             sys_clk,
	input  wire logic             reset,
	input  wire logic [CNT_W-1:0] torque_loop_count,
	input  wire logic [CNT_W-1:0] torque_upper_limit,
	input  wire logic [CNT_W-1:0] torque_lower_limit,
	input  wire logic [POS_W-1:0] indexer_position,
	input  wire logic [POS_W-1:0] zero_position,
	output logic                  above_q,
	output logic                  below_q,
	output logic                  away_q
);

	wire above_d = torque_loop_count > torque_upper_limit;
	wire below_d = torque_loop_count < torque_lower_limit;
	wire away_d  = indexer_position != zero_position;

	// Flags follow their condition as levels, one cycle late
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			above_q <= 1'b0;
			below_q <= 1'b0;
			away_q  <= 1'b0;
		end else begin
			above_q <= above_d;
			below_q <= below_d;
			away_q  <= away_d;
		end
	end

endmodule : torque_limit_compare

// file: dv/regs_chk_sva.sv
// Port checker for the stepper diagnostic and control register bank.
// Bound to every bank instance; parameters follow the instance.
`timescale 1ns/10ps
module regs_chk #(
	parameter int CNT_W        = 8,
	parameter int POS_W        = 10,
	parameter int OFFT0_CYCLES = 5,
	parameter int OFFT1_CYCLES = 10,
	parameter int OFFT2_CYCLES = 15,
	parameter int OFFT3_CYCLES = 20
) (
	input wire logic             sys_clk,
	input wire logic             reset,
	input wire logic             reg_wr_en,
	input wire logic             reg_rd_en,
	input wire logic [7:0]       reg_addr,
	input wire logic [7:0]       reg_wdata,
	input wire logic [7:0]       reg_rdata,
	input wire logic             reg_rd_valid,
	input wire logic [CNT_W-1:0] torque_loop_count,
	input wire logic [CNT_W-1:0] torque_upper_limit,
	input wire logic [CNT_W-1:0] torque_lower_limit,
	input wire logic [POS_W-1:0] indexer_position,
	input wire logic [POS_W-1:0] zero_position,
	input wire logic             bridge_enable,
	input wire logic             slew_select,
	input wire logic [7:0]       slew_time_ns,
	input wire logic             indexer_reset,
	input wire logic [1:0]       off_time_select,
	input wire logic [13:0]      off_time_cycles,
	input wire logic             clear_faults
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);

	function automatic logic [13:0] tc(logic [1:0] s);
		return 14'(s == 2'h0 ? OFFT0_CYCLES : s == 2'h1 ? OFFT1_CYCLES :
			s == 2'h2 ? OFFT2_CYCLES : OFFT3_CYCLES);
	endfunction : tc

	sequence s_rd(logic [7:0] a);
		reg_rd_en && reg_addr == a;
	endsequence
	sequence s_cfg_wr;
		reg_wr_en && reg_addr == 8'h04;
	endsequence
	sequence s_clr_wr;
		reg_wr_en && reg_addr == 8'h06 && reg_wdata[7];
	endsequence
	sequence s_clr_pulse;
		clear_faults ##1 !clear_faults;
	endsequence

	AST_RD_VALID: assert property (reg_rd_en |=> reg_rd_valid)
		else $error("read not answered");
	AST_RD_IDLE: assert property (!reg_rd_en |=> !reg_rd_valid)
		else $error("stray read valid");
	AST_CFG_WR: assert property (s_cfg_wr |=> bridge_enable == $past(reg_wdata[7])
		&& slew_select == $past(reg_wdata[6]) && off_time_select == $past(reg_wdata[4:3]))
		else $error("config outputs do not follow write");
	AST_IDX: assert property (s_cfg_wr |=> indexer_reset == $past(reg_wdata[5]))
		else $error("indexer reset wrong");
	AST_SLEW: assert property (slew_time_ns == ($past(slew_select) ? 8'h46 : 8'h8c))
		else $error("edge time wrong");
	AST_OFF_TIME: assert property (off_time_cycles == tc($past(off_time_select)))
		else $error("off time wrong");
	AST_AWAY: assert property (s_rd(8'h03) |=>
		reg_rdata[6] == ($past(indexer_position, 2) != $past(zero_position, 2)))
		else $error("away flag wrong");
	AST_ABOVE: assert property (s_rd(8'h03) |=>
		reg_rdata[5] == ($past(torque_loop_count, 2) > $past(torque_upper_limit, 2)))
		else $error("above flag wrong");
	AST_BELOW: assert property (s_rd(8'h03) |=>
		reg_rdata[4] == ($past(torque_loop_count, 2) < $past(torque_lower_limit, 2)))
		else $error("below flag wrong");
	AST_RSVD: assert property (s_rd(8'h03) |=> (reg_rdata & 8'h8b) == 8'h00)
		else $error("reserved diag bits set");
	AST_CLR: assert property (s_clr_wr |=> s_clr_pulse)
		else $error("clear pulse wrong");
	AST_CLR_RD: assert property (s_rd(8'h06) |=> !reg_rdata[7])
		else $error("clear bit stored");
endmodule : regs_chk

bind stepper_diag_ctrl_regs regs_chk #(.CNT_W(CNT_W), .POS_W(POS_W),
	.OFFT0_CYCLES(OFFT0_CYCLES), .OFFT1_CYCLES(OFFT1_CYCLES),
	.OFFT2_CYCLES(OFFT2_CYCLES), .OFFT3_CYCLES(OFFT3_CYCLES)) u_chk (.*);

// file: dv/host_model.sv
// Host controller model driving the byte register port.
// Drives on the falling edge; the bank answers reads one cycle later.
`timescale 1ns/10ps
module host_model (
	input  wire logic       sys_clk,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       reg_rd_valid,
	output logic            reg_wr_en,
	output logic            reg_rd_en,
	output logic [7:0]      reg_addr,
	output logic [7:0]      reg_wdata
);
	initial begin
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end

	// Released lines show the inverse so stale values never pass
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		if (a > 8'h0f && a != 8'h1a && a != 8'h3c)
			return;
		if (a == 8'h04 && d[2:0] inside {3'h1, 3'h2, 3'h3})
			return;
		@(negedge sys_clk);
		reg_wr_en = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge sys_clk);
		reg_wr_en = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge sys_clk);
		reg_rd_en = 1'b1;
		reg_addr = a;
		@(negedge sys_clk);
		reg_rd_en = 1'b0;
		reg_addr = ~a;
		d = reg_rd_valid ? reg_rdata : 8'hxx;
	endtask : rd
endmodule : host_model

// file: dv/tb_top.sv
// Self-checking bench for the stepper register bank.
// Host model on the register port; status inputs are driven here.
`timescale 1ns/10ps
module tb_top;
	import stepper_regs_pkg::*;
	typedef struct {logic [7:0] w; fall_scheme_t f; logic [13:0] t; logic [7:0] s;} row_t;
	logic         sys_clk, reset, reg_wr_en, reg_rd_en, reg_rd_valid;
	logic         supply_uv_event, sleep_n, bridge_enable, slew_select;
	logic         indexer_reset, clear_faults;
	logic [1:0]   off_time_select;
	logic [7:0]   reg_addr, reg_wdata, reg_rdata, slew_time_ns, d;
	logic [7:0]   torque_loop_count, torque_upper_limit, torque_lower_limit;
	logic [9:0]   indexer_position, zero_position;
	logic [13:0]  off_time_cycles;
	fall_scheme_t fall_scheme;
	int           num_errors = 0;
	int           check_count = 0;
	int           cyc = 0;
	row_t rows[5] = '{'{8'h00, FALL_SLOW, 14'h5, 8'h8c}, '{8'hcc, FALL_MIXED_30, 14'ha, 8'h46},
		'{8'hb5, FALL_MIXED_60, 14'hf, 8'h8c}, '{8'h7e, FALL_DYNAMIC_TUNE, 14'h14, 8'h46},
		'{8'h0f, FALL_RIPPLE_TUNE, 14'ha, 8'h8c}};
	logic [7:0] adr[16] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a,
		8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h1a, 8'h3c, 8'h10};

	stepper_diag_ctrl_regs #(.OFFT0_CYCLES(5), .OFFT1_CYCLES(10), .OFFT2_CYCLES(15),
		.OFFT3_CYCLES(20)) u_dut (.*);
	host_model u_host (.*);

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// Ceiling is about twenty times the expected run length
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			num_errors++;
			give_verdict();
		end
	end

	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		check_count++;
		if (s !== e) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic give_verdict();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : give_verdict

	function automatic logic [7:0] rst_val(logic [7:0] a);
		case (a)
			8'h04: return 8'h0f;
			8'h05: return 8'h06;
			8'h06: return 8'h38;
			8'h07: return 8'h49;
			default: return 8'h00;
		endcase
	endfunction : rst_val

	// ----------------
	// Main sequence
	// ----------------
	initial begin
		reset = 1'b1;
		{supply_uv_event, sleep_n} = 2'h1;
		{torque_loop_count, torque_upper_limit, torque_lower_limit} = 24'h0;
		{indexer_position, zero_position} = 20'h0;
		repeat (3) @(negedge sys_clk);
		reset = 1'b0;
		foreach (rows[i]) begin
			u_host.wr(8'h04, rows[i].w);
			@(negedge sys_clk);
			u_host.rd(8'h04, d);
			chk("cfg", d, rows[i].w);
			chk("en", bridge_enable, rows[i].w[7]);
			chk("idx", indexer_reset, rows[i].w[5]);
			chk("slew", slew_time_ns, rows[i].s);
			chk("off_time", off_time_cycles, rows[i].t);
			chk("fall", fall_scheme, rows[i].f);
		end
		// Mid-run reset must restore every default
		reset = 1'b1;
		@(negedge sys_clk);
		reset = 1'b0;
		foreach (adr[i]) begin
			u_host.rd(adr[i], d);
			chk("rst", d, rst_val(adr[i]));
		end
		foreach (adr[i]) u_host.wr(adr[i], adr[i] + 8'h21);
		foreach (adr[i]) begin
			u_host.rd(adr[i], d);
			chk("rw", d, (i % 15) ? adr[i] + 8'h21 : 8'h00);
		end
		{torque_upper_limit, torque_lower_limit, torque_loop_count} = 24'h280a29;
		indexer_position = 10'h1;
		u_host.rd(8'h03, d);
		chk("diag", d, 8'h60);
		torque_loop_count = 8'h28;
		indexer_position = 10'h0;
		u_host.rd(8'h03, d);
		chk("diag", d, 8'h00);
		torque_loop_count = 8'h09;
		supply_uv_event = 1'b1;
		@(negedge sys_clk);
		supply_uv_event = 1'b0;
		u_host.rd(8'h03, d);
		chk("diag", d, 8'h10);
		u_host.wr(8'h06, 8'hb8);
		chk("clr", clear_faults, 1'b1);
		@(negedge sys_clk);
		chk("clr", clear_faults, 1'b0);
		u_host.rd(8'h03, d);
		chk("diag", d, 8'h14);
		u_host.rd(8'h06, d);
		chk("ctl", d, 8'h38);
		supply_uv_event = 1'b1;
		@(negedge sys_clk);
		supply_uv_event = 1'b0;
		// A set supply flag must drop again on a fresh undervoltage
		u_host.rd(8'h03, d);
		chk("diag", d, 8'h10);
		sleep_n = 1'b0;
		@(negedge sys_clk);
		sleep_n = 1'b1;
		u_host.rd(8'h03, d);
		chk("diag", d, 8'h14);
		give_verdict();
	end
endmodule : tb_top
